// ---- logic/apc_post_proc.v ----
// Notes on behaviour
// - Bypass mode passes raw samples to output with ten cycles of delay.
// - Digital functions add two extra cycles of latency over bypass.
// - Reset leaves bypass on; software clears it before using functions.
// - Leaving bypass enables the gain stage at 0 dB; bypass disables gain.
// - Gain code steps 0.5 dB from 0 dB to 6 dB.
// - Gain scales full scale, 2 Vpp at 0 dB down to 1 Vpp at 6 dB.
// - Offset loop estimates DC offset and subtracts it every sample.
// - Time constant code 0 is 2^20 cycles, doubling to code 11; rest reserved.
// - Hold freezes the estimate and keeps applying the last value.
// - Offset correction is off after reset; enable after leaving bypass.
// - Chip sleep stops conversion, floats outputs, 100 us wake time.
// - Converter sleep stops only the core, 5 us wake time.
// - Driver-off bit or enable pin floats outputs, 100 ns recovery.
// - A sample rate below 1 MSPS puts the block in low power.
// - Format is twos complement or offset binary, by bit or pin.
// - Overdriven input clamps to the matching full-scale code.
// - Output words are 14 or 12 bits with an aligned word clock.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "apc_defs.vh"
module apc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             i_clock,
  input  wire             i_reset_n,
  // Fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // Drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data,
  // Level
  output wire             o_full,
  output wire             o_empty
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;
  assign o_full      = (count_reg == DEPTH[AW:0]);
  assign o_empty     = (count_reg == {(AW+1){1'b0}});
  assign o_in_ready  = ~o_full;
  assign o_out_valid = ~o_empty;
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push        = i_in_valid & ~o_full;
  assign pop         = i_out_ready & ~o_empty;
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                      : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                      : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
  always @(posedge i_clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end
endmodule // apc_fifo
module apc_post_proc #(
  parameter DATA_W        = 14,
  parameter FIFO_DEPTH    = 8,
  parameter WAKE_CHIP_CYC = (`APC_WAKE_CHIP_NS + `APC_CLK_PERIOD_NS - 1)
                            / `APC_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire              i_clock,
  input  wire              i_reset_n,
  // Register port
  input  wire [7:0]        i_reg_addr,
  input  wire [7:0]        i_reg_wdata,
  input  wire              i_reg_write,
  input  wire              i_reg_read,
  output reg  [7:0]        o_reg_rdata,
  // Configuration pins
  input  wire              i_parallel_cfg,
  input  wire              i_format_select_pin,
  input  wire              i_output_drive_pin,
  // Converter core samples, twos complement
  input  wire              i_sample_valid,
  input  wire [DATA_W-1:0] i_sample,
  input  wire              i_over_range,
  output wire              o_sample_ready,
  // Power control towards the analog core
  output wire              o_core_power_down,
  output wire              o_ref_power_down,
  output wire              o_low_power,
  // Output word bus
  output wire [DATA_W-1:0] o_data,
  output wire              o_data_oe_n,
  output reg               o_word_clock,
  output wire              o_data_valid,
  input  wire              i_data_ready
);
  localparam DLY_N       = `APC_BYPASS_LAT - 1;
  localparam WAKE_CONV_CYC = (`APC_WAKE_CONV_NS + `APC_CLK_PERIOD_NS - 1)
                             / `APC_CLK_PERIOD_NS;
  localparam WAKE_DRV_CYC  = (`APC_WAKE_DRV_NS + `APC_CLK_PERIOD_NS - 1)
                             / `APC_CLK_PERIOD_NS;
  localparam SLOW_CYC      = `APC_SLOW_PERIOD_NS / `APC_CLK_PERIOD_NS;
  localparam CW            = 24;
  localparam AW            = 48;
  localparam signed [AW-1:0] POS_FS = (1 <<< (DATA_W - 1)) - 1;
  localparam signed [AW-1:0] NEG_FS = -(1 <<< (DATA_W - 1));
  // Converts a gain code in half-decibel steps to a factor in Q10.
  function [12:0] gain_factor;
    input [3:0] code;
    begin
      case (code)
        4'h0:    gain_factor = 13'h0400;
        4'h1:    gain_factor = 13'h043d;
        4'h2:    gain_factor = 13'h047d;
        4'h3:    gain_factor = 13'h04c1;
        4'h4:    gain_factor = 13'h0509;
        4'h5:    gain_factor = 13'h0556;
        4'h6:    gain_factor = 13'h05a7;
        4'h7:    gain_factor = 13'h05fc;
        4'h8:    gain_factor = 13'h0657;
        4'h9:    gain_factor = 13'h06b7;
        4'ha:    gain_factor = 13'h071d;
        4'hb:    gain_factor = 13'h0789;
        default: gain_factor = 13'h07fb;
      endcase
    end
  endfunction
  // Saturates a wide signed value to the output word width.
  function [DATA_W-1:0] sat;
    input signed [AW-1:0] v;
    begin
      if (v > POS_FS) begin
        sat = POS_FS[DATA_W-1:0];
      end else if (v < NEG_FS) begin
        sat = NEG_FS[DATA_W-1:0];
      end else begin
        sat = v[DATA_W-1:0];
      end
    end
  endfunction
  reg [7:0]        ctrl_reg;
  reg [3:0]        gain_reg;
  reg [3:0]        tc_reg;
  reg [CW-1:0]     wake_cnt_reg;
  reg              chip_sleep_q_reg;
  reg              conv_sleep_q_reg;
  reg [CW-1:0]     drv_cnt_reg;
  reg              drv_off_q_reg;
  reg [CW-1:0]     gap_cnt_reg;
  reg              low_power_reg;
  reg [DATA_W:0]   dly_reg [0:DLY_N-1];
  reg [DLY_N-1:0]  dly_vld_reg;
  reg [DATA_W-1:0] gain_out_reg;
  reg              gain_vld_reg;
  reg [DATA_W-1:0] ofs_out_reg;
  reg              ofs_vld_reg;
  reg signed [AW-1:0] acc_reg;
  wire             bypass;
  wire             chip_sleep;
  wire             conv_sleep;
  wire             drv_off;
  wire             adc_running;
  wire             advance;
  wire [DATA_W:0]  raw_tail;
  wire [DATA_W-1:0] clamped;
  wire signed [DATA_W+13:0] prod;
  wire [3:0]       tc_eff;
  wire [5:0]       shift;
  wire signed [AW-1:0] est;
  wire signed [AW-1:0] err;
  wire             ofs_run;
  wire             fmt_obin;
  wire [DATA_W-1:0] pre_fmt;
  wire             pre_vld;
  wire [DATA_W-1:0] push_data;
  wire             fifo_full;
  wire             fifo_empty;
  wire             out_valid;
  assign bypass     = ~ctrl_reg[`APC_CTRL_BYPASS_OFF];
  assign chip_sleep = ctrl_reg[`APC_CTRL_CHIP_SLEEP];
  assign conv_sleep = ctrl_reg[`APC_CTRL_CONV_SLEEP];
  assign drv_off    = ctrl_reg[`APC_CTRL_DRV_OFF] | ~i_output_drive_pin;
  // Register port writes.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      ctrl_reg <= `APC_CTRL_RESET;
      gain_reg <= `APC_GAIN_RESET;
      tc_reg   <= `APC_TC_RESET;
    end else if (i_reg_write) begin
      case (i_reg_addr)
        `APC_ADDR_CTRL: ctrl_reg <= i_reg_wdata;
        `APC_ADDR_GAIN: gain_reg <= i_reg_wdata[3:0];
        `APC_ADDR_TC:   tc_reg   <= i_reg_wdata[3:0];
        default:        ctrl_reg <= ctrl_reg;
      endcase
    end
  end
  // Register port reads; unmapped offsets read as zero.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_read) begin
      case (i_reg_addr)
        `APC_ADDR_CTRL:   o_reg_rdata <= ctrl_reg;
        `APC_ADDR_GAIN:   o_reg_rdata <= {4'h0, gain_reg};
        `APC_ADDR_TC:     o_reg_rdata <= {4'h0, tc_reg};
        `APC_ADDR_STATUS: o_reg_rdata <= {fifo_empty, fifo_full,
                                          ~o_data_oe_n,
                                          (wake_cnt_reg != {CW{1'b0}}),
                                          low_power_reg, ofs_run,
                                          ~bypass, bypass};
        `APC_ADDR_EST_LO: o_reg_rdata <= est[7:0];
        `APC_ADDR_EST_HI: o_reg_rdata <= est[15:8];
        default:          o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end
  // The wake timer restarts on leaving chip sleep, and on leaving converter sleep it is raised to the converter wake time if lower; samples stay blocked
  // until the core has settled, so stale words never reach the bus.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      wake_cnt_reg     <= {CW{1'b0}};
      chip_sleep_q_reg <= 1'b0;
      conv_sleep_q_reg <= 1'b0;
    end else begin
      chip_sleep_q_reg <= chip_sleep;
      conv_sleep_q_reg <= conv_sleep;
      if (chip_sleep_q_reg & ~chip_sleep) begin
        wake_cnt_reg <= WAKE_CHIP_CYC[CW-1:0];
      end else if (conv_sleep_q_reg & ~conv_sleep & ~chip_sleep) begin
        if (wake_cnt_reg < WAKE_CONV_CYC[CW-1:0]) begin
          wake_cnt_reg <= WAKE_CONV_CYC[CW-1:0];
        end
      end else if (wake_cnt_reg != {CW{1'b0}}) begin
        wake_cnt_reg <= wake_cnt_reg - 1'b1;
      end
    end
  end
  // Driver recovery delay after the drivers are switched back on.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      drv_cnt_reg   <= {CW{1'b0}};
      drv_off_q_reg <= 1'b0;
    end else begin
      drv_off_q_reg <= drv_off;
      if (drv_off_q_reg & ~drv_off) begin
        drv_cnt_reg <= WAKE_DRV_CYC[CW-1:0];
      end else if (drv_cnt_reg != {CW{1'b0}}) begin
        drv_cnt_reg <= drv_cnt_reg - 1'b1;
      end
    end
  end
  // A gap of more than one microsecond between samples means the sample
  // clock is below 1 MSPS; the first sample after the gap wakes the core.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      gap_cnt_reg   <= {CW{1'b0}};
      low_power_reg <= 1'b0;
    end else if (i_sample_valid) begin
      gap_cnt_reg   <= {CW{1'b0}};
      low_power_reg <= 1'b0;
    end else if (gap_cnt_reg >= SLOW_CYC[CW-1:0]) begin
      low_power_reg <= 1'b1;
    end else begin
      gap_cnt_reg <= gap_cnt_reg + 1'b1;
    end
  end
  assign o_core_power_down = chip_sleep | conv_sleep | low_power_reg;
  assign o_ref_power_down  = chip_sleep;
  assign o_low_power       = low_power_reg;
  assign adc_running = ~chip_sleep & ~conv_sleep &
                       (wake_cnt_reg == {CW{1'b0}});
  // The whole pipeline stalls while the FIFO is full.
  assign advance        = ~fifo_full;
  assign o_sample_ready = advance;
  // Raw delay line; the FIFO write is the last of the bypass stages.
  genvar gi;
  generate
    for (gi = 0; gi < DLY_N; gi = gi + 1) begin : g_dly
      localparam PREV = (gi == 0) ? 0 : gi - 1;
      always @(posedge i_clock) begin
        if (!i_reset_n) begin
          dly_reg[gi]     <= {(DATA_W+1){1'b0}};
          dly_vld_reg[gi] <= 1'b0;
        end else if (advance) begin
          dly_reg[gi]     <= (gi == 0) ? {i_over_range, i_sample}
                                       : dly_reg[PREV];
          dly_vld_reg[gi] <= (gi == 0) ? (i_sample_valid & adc_running)
                                       : dly_vld_reg[PREV];
        end
      end
    end
  endgenerate
  assign raw_tail = dly_reg[DLY_N-1];
  assign clamped  = raw_tail[DATA_W] ?
                    (raw_tail[DATA_W-1] ? NEG_FS[DATA_W-1:0]
                                        : POS_FS[DATA_W-1:0])
                    : raw_tail[DATA_W-1:0];
  // Gain stage; a code above 6 dB is held at 6 dB.
  assign prod = $signed(clamped) *
                $signed({1'b0, gain_factor((gain_reg > `APC_GAIN_MAX) ?
                                           `APC_GAIN_MAX : gain_reg)});
  // Offset loop: the estimate is the accumulator scaled by the time
  // constant, so the accumulator moves by the residual on every valid sample while the loop is enabled and hold is clear.
  assign tc_eff  = (tc_reg > `APC_TC_MAX) ? `APC_TC_MAX : tc_reg;
  assign shift   = `APC_TC_BASE_SHIFT + {2'b00, tc_eff};
  assign est     = acc_reg >>> shift;
  assign err     = $signed({{(AW-DATA_W){gain_out_reg[DATA_W-1]}},
                            gain_out_reg}) - est;
  assign ofs_run = ~bypass & ctrl_reg[`APC_CTRL_OFS_EN] &
                   ~ctrl_reg[`APC_CTRL_OFS_HOLD];
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      gain_out_reg <= {DATA_W{1'b0}};
      gain_vld_reg <= 1'b0;
      ofs_out_reg  <= {DATA_W{1'b0}};
      ofs_vld_reg  <= 1'b0;
      acc_reg      <= {AW{1'b0}};
    end else begin
      if (advance) begin
        gain_out_reg <= sat($signed({{(AW-DATA_W-14){prod[DATA_W+13]}},
                                     prod}) >>> 10);
        gain_vld_reg <= dly_vld_reg[DLY_N-1] & ~bypass;
        ofs_vld_reg  <= gain_vld_reg;
        if (~bypass & ctrl_reg[`APC_CTRL_OFS_EN]) begin
          ofs_out_reg <= sat(err);
        end else begin
          ofs_out_reg <= gain_out_reg;
        end
      end
      if (bypass | ~ctrl_reg[`APC_CTRL_OFS_EN]) begin
        acc_reg <= {AW{1'b0}};
      end else if (ofs_run & advance & gain_vld_reg) begin
        acc_reg <= acc_reg + err;
      end
    end
  end
  // Bypass takes the raw tail; otherwise the two processing stages.
  assign pre_fmt  = bypass ? clamped : ofs_out_reg;
  assign pre_vld  = bypass ? dly_vld_reg[DLY_N-1] : ofs_vld_reg;
  assign fmt_obin = i_parallel_cfg ? i_format_select_pin
                                   : ctrl_reg[`APC_CTRL_FMT_OBIN];
  assign push_data = {pre_fmt[DATA_W-1] ^ fmt_obin,
                      pre_fmt[DATA_W-2:0]};
  apc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (pre_vld & advance),
    .o_in_ready  (),
    .i_in_data   (push_data),
    .o_out_valid (out_valid),
    .i_out_ready (i_data_ready & ~o_data_oe_n),
    .o_out_data  (o_data),
    .o_full      (fifo_full),
    .o_empty     (fifo_empty)
  );
  // Drivers float in chip sleep, driver-off, or during recovery.
  assign o_data_oe_n  = chip_sleep | drv_off |
                        (drv_cnt_reg != {CW{1'b0}});
  assign o_data_valid = out_valid & ~o_data_oe_n;
  // Word clock is high for the one cycle after each word is taken, so the
  // receiver can latch on its rising edge.
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_word_clock <= 1'b0;
    end else begin
      o_word_clock <= o_data_valid & i_data_ready;
    end
  end
endmodule // apc_post_proc

// ---- logic/apc_defs.vh ----
`ifndef APC_DEFS_VH
`define APC_DEFS_VH

// Register offsets on the plain register port.
`define APC_ADDR_CTRL       8'h00
`define APC_ADDR_GAIN       8'h01
`define APC_ADDR_TC         8'h02
`define APC_ADDR_STATUS     8'h03
`define APC_ADDR_EST_LO     8'h04
`define APC_ADDR_EST_HI     8'h05

// Control register fields.
`define APC_CTRL_BYPASS_OFF 0
`define APC_CTRL_OFS_EN     1
`define APC_CTRL_OFS_HOLD   2
`define APC_CTRL_CHIP_SLEEP 3
`define APC_CTRL_CONV_SLEEP 4
`define APC_CTRL_DRV_OFF    5
`define APC_CTRL_FMT_OBIN   6
`define APC_CTRL_RESET      8'h00
`define APC_GAIN_RESET      4'h0
`define APC_TC_RESET        4'h0

// Gain codes are half-decibel steps; the last code is 6 dB.
`define APC_GAIN_MAX        4'hc
// Offset loop time constant code range; code 0 is 2^20 cycles.
`define APC_TC_MAX          4'hb
`define APC_TC_BASE_SHIFT   6'h14

// Timing, each figure in its own unit.
`define APC_CLK_PERIOD_NS   20
`define APC_BYPASS_LAT      10
`define APC_PROC_EXTRA      2
`define APC_WAKE_CHIP_NS    100000
`define APC_WAKE_CONV_NS    5000
`define APC_WAKE_DRV_NS     100
`define APC_SLOW_PERIOD_NS  1000

`endif

// ---- bench/apc_post_proc_assertions.sv ----
`timescale 1ns/10ps
`include "apc_defs.vh"
module apc_post_proc_assertions #(
  parameter DATA_W = 14
) (
  // Clock and reset
  input wire              i_clock,
  input wire              i_reset_n,
  // Inputs watched
  input wire [7:0]        i_reg_addr,
  input wire [7:0]        i_reg_wdata,
  input wire              i_reg_write,
  input wire              i_output_drive_pin,
  input wire              i_sample_valid,
  input wire              i_data_ready,
  // Outputs watched
  input wire              o_ref_power_down,
  input wire              o_core_power_down,
  input wire              o_low_power,
  input wire [DATA_W-1:0] o_data,
  input wire              o_data_oe_n,
  input wire              o_word_clock,
  input wire              o_data_valid
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // The idle threshold is far past what a repetition may span, so the
  // gap between samples is counted here.
  reg  [7:0] idle_reg;
  wire       ctrl_wr = i_reg_write && (i_reg_addr == `APC_ADDR_CTRL);
  always @(posedge i_clock) begin
    if (!i_reset_n || i_sample_valid) idle_reg <= 8'h00;
    else if (idle_reg != 8'hff) idle_reg <= idle_reg + 8'h01;
  end
  sequence s_taken;
    o_data_valid && i_data_ready;
  endsequence
  sequence s_waiting;
    o_data_valid && !i_data_ready ##1 o_data_valid;
  endsequence
  chip_sleep_a: assert property (
    ctrl_wr && i_reg_wdata[`APC_CTRL_CHIP_SLEEP] |=> o_ref_power_down)
    else $error("chip sleep write ignored");
  conv_sleep_a: assert property (
    ctrl_wr && i_reg_wdata[4:3] == 2'h2 |=>
      o_core_power_down && !o_ref_power_down)
    else $error("converter sleep wrong");
  ref_core_a: assert property (
    o_ref_power_down |-> o_core_power_down && o_data_oe_n)
    else $error("chip sleep incomplete");
  pin_float_a: assert property (
    !i_output_drive_pin [*2] |-> o_data_oe_n)
    else $error("enable pin low but drivers on");
  float_quiet_a: assert property (
    o_data_oe_n |-> !o_data_valid)
    else $error("word offered while floated");
  word_clock_a: assert property (s_taken |=> o_word_clock)
    else $error("no word clock after a taken word");
  clock_cause_a: assert property (
    o_word_clock |-> $past(o_data_valid && i_data_ready))
    else $error("word clock without a taken word");
  head_hold_a: assert property (s_waiting |-> $stable(o_data))
    else $error("head word changed before taken");
  idle_power_a: assert property (idle_reg >= 8'h37 |-> o_low_power)
    else $error("no low power after long idle");
  idle_core_a: assert property (o_low_power |-> o_core_power_down)
    else $error("low power left core running");
endmodule // apc_post_proc_assertions

// ---- bench/apc_rx_model.sv ----
`timescale 1ns/10ps
module apc_rx_model #(
  parameter DW = 14
) (
  // Clock, reset and pace: 0 prompt, 1 erratic, 2 stopped
  input  wire          i_clock,
  input  wire          i_reset_n,
  input  wire [1:0]    i_mode,
  // Word bus
  input  wire [DW-1:0] i_data,
  input  wire          i_data_oe_n,
  input  wire          i_data_valid,
  output reg           o_ready = 1'b0
);
  reg [DW-1:0] got[$];
  reg [7:0]    lfsr_reg = 8'h5a;
  reg          take_reg = 1'b0;
  reg [DW-1:0] word_reg = {DW{1'b0}};
  // Sampling half a cycle early keeps capture clear of the head move.
  always @(negedge i_clock) begin
    take_reg <= i_data_valid && o_ready && !i_data_oe_n;
    word_reg <= i_data;
  end
  always @(posedge i_clock) begin
    lfsr_reg <= {lfsr_reg[6:0], ^(lfsr_reg & 8'hb8)};
    if (!i_reset_n) begin
      o_ready <= 1'b0;
      got.delete();
    end else begin
      o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && lfsr_reg[0]);
      if (take_reg) got.push_back(word_reg);
    end
  end
endmodule // apc_rx_model

// ---- bench/apc_post_proc_bench.sv ----
`timescale 1ns/10ps
`include "apc_defs.vh"
module apc_post_proc_bench;
  localparam DW = 14;
  reg           i_clock = 1'b0;
  reg           i_reset_n = 1'b0;
  reg  [7:0]    i_reg_addr = 8'h00;
  reg  [7:0]    i_reg_wdata = 8'h00;
  reg           i_reg_write = 1'b0;
  reg           i_reg_read = 1'b0;
  reg           i_parallel_cfg = 1'b1;
  reg           i_format_select_pin = 1'b0;
  reg           i_output_drive_pin = 1'b1;
  reg           i_sample_valid = 1'b0;
  reg  [DW-1:0] i_sample = 14'h0000;
  reg           i_over_range = 1'b0;
  reg  [1:0]    rx_mode = 2'h0;
  reg  [31:0]   seed = 32'h8e339341;
  reg  [DW-1:0] exp_q[$];
  reg           obin = 1'b0;
  reg           gsat = 1'b0;
  reg           took = 1'b0;
  integer       bad_count = 0;
  integer       samples_checked = 0;
  integer       n, k, m;
  wire [7:0]    o_reg_rdata;
  wire [DW-1:0] o_data;
  wire          o_sample_ready, o_core_power_down, o_ref_power_down;
  wire          o_low_power, o_data_oe_n, o_word_clock, o_data_valid;
  wire          rx_ready;
  apc_post_proc #(.DATA_W(DW), .FIFO_DEPTH(8), .WAKE_CHIP_CYC(20)) dut_u (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
    .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
    .i_parallel_cfg(i_parallel_cfg),
    .i_format_select_pin(i_format_select_pin),
    .i_output_drive_pin(i_output_drive_pin),
    .i_sample_valid(i_sample_valid), .i_sample(i_sample),
    .i_over_range(i_over_range), .o_sample_ready(o_sample_ready),
    .o_core_power_down(o_core_power_down),
    .o_ref_power_down(o_ref_power_down), .o_low_power(o_low_power),
    .o_data(o_data), .o_data_oe_n(o_data_oe_n),
    .o_word_clock(o_word_clock), .o_data_valid(o_data_valid),
    .i_data_ready(rx_ready));
  apc_rx_model #(.DW(DW)) rx_u (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_mode(rx_mode), .i_data(o_data), .i_data_oe_n(o_data_oe_n),
    .i_data_valid(o_data_valid), .o_ready(rx_ready));
  initial begin
    forever #10 i_clock = ~i_clock;
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [DW-1:0] exp_word(input [DW-1:0] s, input ovr);
    reg [DW-1:0] v;
    begin
      v = s;
      if (ovr || gsat) v = s[DW-1] ? 14'h2000 : 14'h1fff;
      if (obin) v[DW-1] = ~v[DW-1];
      exp_word = v;
    end
  endfunction
  task check(input [31:0] seen, input [31:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  // A sample counts as accepted only where the pipeline advanced.
  always @(negedge i_clock) took <= i_sample_valid && o_sample_ready;
  always @(posedge i_clock) begin
    if (took) exp_q.push_back(exp_word(i_sample, i_over_range));
  end
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_clock);
      i_reg_write <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clock);
      i_reg_write <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] mask, input [7:0] want);
    begin
      @(posedge i_clock);
      i_reg_read <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clock);
      i_reg_read <= 1'b0;
      #1 check(o_reg_rdata & mask, want);
    end
  endtask
  task stream(input integer cnt);
    begin
      for (k = 0; k < cnt; k = k + 1) begin
        @(posedge i_clock);
        seed = xs(seed);
        i_sample_valid <= 1'b1;
        i_sample <= seed[DW-1:0];
        i_over_range <= (seed[31:29] == 3'h0);
      end
      @(posedge i_clock);
      i_sample_valid <= 1'b0;
    end
  endtask
  task lat(input [DW-1:0] s, input integer want);
    begin
      @(posedge i_clock);
      i_sample_valid <= 1'b1;
      i_sample <= s;
      i_over_range <= 1'b0;
      @(posedge i_clock);
      i_sample_valid <= 1'b0;
      #1 n = 1;
      while (o_data_valid !== 1'b1 && n < 40) begin
        @(posedge i_clock);
        #1 n = n + 1;
      end
      check(n, want);
    end
  endtask
  task drain;
    begin
      for (n = 0; rx_u.got.size() < exp_q.size() && n < 400; n = n + 1)
        @(posedge i_clock);
      check(rx_u.got.size(), exp_q.size());
      while (exp_q.size() > 0 && rx_u.got.size() > 0)
        check(rx_u.got.pop_front(), exp_q.pop_front());
    end
  endtask
  task close_out;
    begin
      $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    #400000;
    bad_count = bad_count + 1;
    close_out;
  end
  initial begin
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rdc(`APC_ADDR_STATUS, 8'hff, 8'ha1);
    rdc(`APC_ADDR_CTRL, 8'hff, `APC_CTRL_RESET);
    rdc(8'h3f, 8'hff, 8'h00);
    lat(14'h0123, `APC_BYPASS_LAT);
    rx_mode <= 2'h2;
    stream(30);
    #1 check(o_sample_ready, 1'b0);
    rx_mode <= 2'h0;
    drain;
    // Rows: erratic receiver with pin format, then register format, then pin twos complement.
    for (m = 0; m < 3; m = m + 1) begin
      rx_mode <= (m == 0) ? 2'h1 : 2'h0;
      i_parallel_cfg <= (m != 1);
      i_format_select_pin <= (m == 0);
      obin = (m < 2);
      if (m == 1) wr(`APC_ADDR_CTRL, 8'h40);
      stream(24);
      drain;
    end
    wr(`APC_ADDR_CTRL, 8'h01);
    rdc(`APC_ADDR_STATUS, 8'h03, 8'h02);
    lat(14'h0a5c, `APC_BYPASS_LAT + `APC_PROC_EXTRA);
    gsat = 1'b1;
    wr(`APC_ADDR_GAIN, 8'h01);
    lat(14'h1f00, `APC_BYPASS_LAT + `APC_PROC_EXTRA);
    wr(`APC_ADDR_GAIN, {4'h0, `APC_GAIN_MAX});
    lat(14'h1800, `APC_BYPASS_LAT + `APC_PROC_EXTRA);
    lat(14'h2800, `APC_BYPASS_LAT + `APC_PROC_EXTRA);
    drain;
    gsat = 1'b0;
    wr(`APC_ADDR_TC, {4'h0, `APC_TC_MAX});
    rdc(`APC_ADDR_TC, 8'h0f, 8'h0b);
    wr(`APC_ADDR_CTRL, 8'h03);
    rdc(`APC_ADDR_STATUS, 8'h04, 8'h04);
    wr(`APC_ADDR_CTRL, 8'h07);
    rdc(`APC_ADDR_STATUS, 8'h04, 8'h00);
    rdc(`APC_ADDR_EST_HI, 8'hff, 8'h00);
    wr(`APC_ADDR_CTRL, 8'h08);
    rdc(`APC_ADDR_STATUS, 8'h20, 8'h00);
    wr(`APC_ADDR_CTRL, 8'h00);
    rdc(`APC_ADDR_STATUS, 8'h10, 8'h10);
    repeat (25) @(posedge i_clock);
    rdc(`APC_ADDR_STATUS, 8'h10, 8'h00);
    wr(`APC_ADDR_CTRL, 8'h10);
    #1 check(o_ref_power_down, 1'b0);
    wr(`APC_ADDR_CTRL, 8'h00);
    repeat (200) @(posedge i_clock);
    rdc(`APC_ADDR_STATUS, 8'h10, 8'h10);
    repeat (60) @(posedge i_clock);
    rdc(`APC_ADDR_STATUS, 8'h10, 8'h00);
    wr(`APC_ADDR_CTRL, 8'h20);
    #1 check(o_data_oe_n, 1'b1);
    stream(4);
    wr(`APC_ADDR_CTRL, 8'h00);
    repeat (`APC_WAKE_DRV_NS / `APC_CLK_PERIOD_NS + 2) @(posedge i_clock);
    #1 check(o_data_oe_n, 1'b0);
    drain;
    @(posedge i_clock);
    i_output_drive_pin <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1 check(o_data_oe_n, 1'b1);
    repeat (60) @(posedge i_clock);
    i_output_drive_pin <= 1'b1;
    rdc(`APC_ADDR_STATUS, 8'h08, 8'h08);
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rdc(`APC_ADDR_STATUS, 8'hff, 8'ha1);
    lat(14'h3333, `APC_BYPASS_LAT);
    drain;
    close_out;
  end
endmodule // apc_post_proc_bench
bind apc_post_proc apc_post_proc_assertions #(.DATA_W(DATA_W)) chk_u (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
  .i_output_drive_pin(i_output_drive_pin),
  .i_sample_valid(i_sample_valid), .i_data_ready(i_data_ready),
  .o_ref_power_down(o_ref_power_down),
  .o_core_power_down(o_core_power_down), .o_low_power(o_low_power),
  .o_data(o_data), .o_data_oe_n(o_data_oe_n),
  .o_word_clock(o_word_clock), .o_data_valid(o_data_valid));
